// file: src/sppm_pkg.sv
// constants, types and the function list for the switch port power block
// assumes one switch core clock at 50 MHz and plain-port control bits
//
// Function
// - a bridge in D3hot asks its own link for L1, ignoring other ports
// - upstream low power plus all acks puts the whole switch in low power
// - power-on reset gives D0 uninitialized; configuration moves it to D0 active
// - writing D3hot code from D0 active enters D3hot; D0 code returns uninitialized
// - leaving D3hot resets nothing; context kept flag defaults to set
// - in D3hot type 0 configuration reads and writes complete normally
// - in D3hot messages targeting the bridge are accepted and processed
// - in D3hot other primary requests and all secondary requests are unsupported
// - in D3hot packet errors report as in D0, other errors are dropped
// - in D3hot completions targeting the bridge are unexpected completions
// - in D3hot completions passing through route as in D0
// - no wake from D3cold; downstream hot-plug wake allowed from D3hot
// - after a wake message a timer runs; still pending at expiry means resend
// - turn-off handshake is accepted in every power state
// - an upstream turn-off is forwarded on every active downstream port
// - when all active ports acked, one ack goes upstream and link to L2/L3 ready
// - a packet upstream after turn-off and before the ack abandons aggregation
// - once the ack is scheduled aggregation is done; later packets may be dropped
// - abandoning packets go to the switch, or to a port, waking its link first
// - abandoning does not cancel downstream handshakes already sent
// - a port missing its ack by its time-out acts as if acknowledged
// - returning to D0 uninitialized after the handshake resumes wake messages
package sppm_pkg;
    localparam int NPORT = 3;
    localparam int NDOWN = 2;
    localparam logic [1:0] PS_D0    = 2'h0;
    localparam logic [1:0] PS_D3HOT = 2'h3;
    localparam logic       CONTEXT_KEPT_RST = 1'h1;
    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

    typedef enum logic [1:0] {
        SPPM_D0_UNINIT = 2'b00,
        SPPM_D0_ACTIVE = 2'b01,
        SPPM_D3_HOT    = 2'b11
    } sppm_pm_e;

    typedef enum logic [1:0] {
        SPPM_AG_IDLE = 2'b00,
        SPPM_AG_WAIT = 2'b01,
        SPPM_AG_DONE = 2'b10
    } sppm_ag_e;

    // packet dispositions returned by the filter
    typedef enum logic [1:0] {
        SPPM_DISP_NORMAL = 2'b00,
        SPPM_DISP_UR     = 2'b01,
        SPPM_DISP_UC     = 2'b10,
        SPPM_DISP_DROP   = 2'b11
    } sppm_disp_e;
endpackage

// file: src/sppm_down_timer.sv
// per downstream port: wake retry timer and turn-off ack timer
// assumes enable, requests and clears come from the same clock domain
`timescale 1ns/1ps
module sppm_down_timer
(
    input  wire logic                         clock_i,     // core clock
    input  wire logic                         rst_n_i,     // sync reset
    input  wire logic                         ce_i,        // clock enable
    input  wire logic                         wake_ok_i,   // wake allowed
    input  wire logic                         wake_ev_i,   // hot-plug event
    input  wire logic                         wake_clr_i,  // sw clears status
    input  wire logic [sppm_pkg::TMR_W-1:0]   wake_to_i,   // retry time-out
    input  wire logic                         to_send_i,   // turn-off sent
    input  wire logic                         to_ack_i,    // ack received
    input  wire logic [sppm_pkg::TMR_W-1:0]   ack_to_i,    // ack time-out
    output logic                              wake_msg_o,  // send wake msg
    output logic                              wake_sts_o,  // wake status
    output logic                              acked_o,     // acked or timed
    output logic                              ack_tout_o   // time-out seen
);
    logic                       sts_reg, sts_next;
    logic [sppm_pkg::TMR_W-1:0] wtmr_reg, wtmr_next;
    logic                       msg_reg, msg_next;
    logic                       wait_reg, wait_next;
    logic [sppm_pkg::TMR_W-1:0] atmr_reg, atmr_next;
    logic                       acked_reg, acked_next;
    logic                       tout_reg, tout_next;

    always_comb
    begin
        sts_next  = sts_reg;
        wtmr_next = wtmr_reg;
        msg_next  = 1'b0;
        if (wake_clr_i)
            sts_next = 1'b0;
        if (wtmr_reg != '0)
            wtmr_next = wtmr_reg - sppm_pkg::TMR_ONE;
        if (wake_ok_i && wake_ev_i && !sts_reg)
        begin
            sts_next  = 1'b1;
            msg_next  = 1'b1;
            wtmr_next = wake_to_i;
        end
        else if (wake_ok_i && sts_reg && !wake_clr_i
                 && wtmr_reg == sppm_pkg::TMR_ONE)
        begin
            msg_next  = 1'b1;
            wtmr_next = wake_to_i;
        end
        wait_next  = wait_reg;
        atmr_next  = atmr_reg;
        acked_next = acked_reg;
        tout_next  = tout_reg;
        if (to_send_i)
        begin
            wait_next  = 1'b1;
            atmr_next  = ack_to_i;
            acked_next = 1'b0;
            tout_next  = 1'b0;
        end
        else if (wait_reg)
        begin
            if (to_ack_i)
            begin
                wait_next  = 1'b0;
                acked_next = 1'b1;
            end
            else if (atmr_reg <= sppm_pkg::TMR_ONE)
            begin
                wait_next  = 1'b0;
                acked_next = 1'b1;
                tout_next  = 1'b1;
            end
            else
                atmr_next = atmr_reg - sppm_pkg::TMR_ONE;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sts_reg   <= 1'b0;
            wtmr_reg  <= '0;
            msg_reg   <= 1'b0;
            wait_reg  <= 1'b0;
            atmr_reg  <= '0;
            acked_reg <= 1'b0;
            tout_reg  <= 1'b0;
        end
        else if (ce_i)
        begin
            sts_reg   <= sts_next;
            wtmr_reg  <= wtmr_next;
            msg_reg   <= msg_next;
            wait_reg  <= wait_next;
            atmr_reg  <= atmr_next;
            acked_reg <= acked_next;
            tout_reg  <= tout_next;
        end
    end

    assign wake_msg_o = msg_reg;
    assign wake_sts_o = sts_reg;
    assign acked_o    = acked_reg;
    assign ack_tout_o = tout_reg;
endmodule

// file: src/sppm_top.sv
// per-port power state, D3hot filtering, wake and turn-off aggregation
// assumes packet classification and link state machines sit outside
// port 0 is upstream, ports 1..NDOWN are downstream
`timescale 1ns/1ps
module sppm_top
(
    input  wire logic                   clock_i,        // core clock
    input  wire logic                   rst_n_i,        // sync reset, low
    input  wire logic                   ce_i,           // clock enable
    input  wire logic [2:0]             cfg_done_i,     // bridge configured
    input  wire logic [2:0]             ps_wr_i,        // state field write
    input  wire logic [5:0]             ps_wdata_i,     // 2 bits per port
    output logic      [5:0]             ps_rdata_o,     // state field read
    output logic      [2:0]             context_kept_o, // context kept flag
    output logic      [2:0]             pm_state_o,     // d3hot per port
    output logic      [2:0]             l1_req_o,       // ask link for L1
    output logic                        sw_low_power_o, // whole switch low
    input  wire logic                   pkt_vld_i,      // packet classify
    input  wire logic [1:0]             pkt_port_i,     // arrival port
    input  wire logic                   pkt_sec_i,      // secondary side
    input  wire logic                   pkt_req_i,      // is request
    input  wire logic                   pkt_cfg0_i,     // type 0 config
    input  wire logic                   pkt_msg_i,      // message
    input  wire logic                   pkt_self_i,     // targets bridge
    input  wire logic                   pkt_err_i,      // packet error
    output logic [1:0]                  pkt_disp_o,     // disposition
    output logic                        pkt_err_rpt_o,  // report error
    input  wire logic [2:0]             oth_err_i,      // non-packet error
    output logic [2:0]                  oth_err_rpt_o,  // reported
    input  wire logic [1:0]             hp_ev_i,        // hot-plug events
    input  wire logic [1:0]             wake_clr_i,     // clear wake status
    input  wire logic [31:0]            wake_to_i,      // retry time-outs
    input  wire logic [31:0]            ack_to_i,       // ack time-outs
    input  wire logic                   d3cold_i,       // aux power only
    output logic [1:0]                  wake_msg_o,     // send wake msg
    output logic [1:0]                  wake_sts_o,     // wake status bits
    input  wire logic                   turnoff_i,      // turn-off upstream
    input  wire logic [1:0]             dn_active_i,    // active down port
    input  wire logic [1:0]             dn_l0_i,        // down link in L0
    input  wire logic [1:0]             dn_ack_i,       // ack from down
    input  wire logic                   up_pkt_i,       // packet upstream
    input  wire logic                   up_pkt_self_i,  // it targets switch
    input  wire logic [1:0]             up_pkt_dn_i,    // its down target
    output logic [1:0]                  dn_turnoff_o,   // forward turn-off
    output logic                        up_ack_o,       // send ack upstream
    output logic                        up_l23_o,       // up to L2/L3 ready
    output logic [1:0]                  dn_l23_o,       // down to L2/L3
    output logic [1:0]                  dn_ack_tout_o,  // ack time-out
    output logic [1:0]                  dn_wake_link_o, // detect then L0
    output logic [1:0]                  dn_send_o,      // send held packet
    output logic                        up_drop_o,      // may discard
    output logic                        agg_abandon_o   // abandon pulse
);
    sppm_pkg::sppm_pm_e pm_reg [3];
    sppm_pkg::sppm_pm_e pm_next [3];
    sppm_pkg::sppm_ag_e ag_reg, ag_next;
    logic       ack_reg, ack_next;
    logic       l23_reg, l23_next;
    logic       aban_reg, aban_next;
    logic [1:0] fwd_reg, fwd_next;
    logic [1:0] hold_reg, hold_next;
    logic [1:0] send_reg, send_next;
    logic [1:0] disp_reg, disp_next;
    logic       erpt_reg, erpt_next;
    logic [1:0] dn_acked;
    logic [1:0] d3_seen;
    logic       in_d3;

    // power state machines, one per bridge
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            pm_next[p] = pm_reg[p];
            case (pm_reg[p])
                sppm_pkg::SPPM_D0_UNINIT:
                    if (cfg_done_i[p])
                        pm_next[p] = sppm_pkg::SPPM_D0_ACTIVE;
                sppm_pkg::SPPM_D0_ACTIVE:
                    if (ps_wr_i[p] && ps_wdata_i[2*p +: 2] == sppm_pkg::PS_D3HOT)
                        pm_next[p] = sppm_pkg::SPPM_D3_HOT;
                sppm_pkg::SPPM_D3_HOT:
                    if (ps_wr_i[p] && ps_wdata_i[2*p +: 2] == sppm_pkg::PS_D0)
                        pm_next[p] = sppm_pkg::SPPM_D0_UNINIT;
                default:
                    pm_next[p] = sppm_pkg::SPPM_D0_UNINIT;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            for (int p = 0; p < 3; p++)
                pm_reg[p] <= sppm_pkg::SPPM_D0_UNINIT;
        end
        else if (ce_i)
        begin
            for (int p = 0; p < 3; p++)
                pm_reg[p] <= pm_next[p];
        end
    end

    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            pm_state_o[p] = (pm_reg[p] == sppm_pkg::SPPM_D3_HOT);
            ps_rdata_o[2*p +: 2] = pm_state_o[p] ? sppm_pkg::PS_D3HOT
                                                 : sppm_pkg::PS_D0;
            context_kept_o[p] = sppm_pkg::CONTEXT_KEPT_RST;
            l1_req_o[p] = pm_state_o[p];
            oth_err_rpt_o[p] = oth_err_i[p] && !pm_state_o[p];
        end
    end

    // packet filtering in D3hot
    always_comb
    begin
        in_d3 = pm_state_o[pkt_port_i];
        disp_next = sppm_pkg::SPPM_DISP_NORMAL;
        erpt_next = pkt_vld_i && pkt_err_i;
        if (pkt_vld_i && in_d3)
        begin
            if (!pkt_req_i)
                disp_next = pkt_self_i ? sppm_pkg::SPPM_DISP_UC
                                       : sppm_pkg::SPPM_DISP_NORMAL;
            else if (pkt_sec_i)
                disp_next = sppm_pkg::SPPM_DISP_UR;
            else if (pkt_cfg0_i)
                disp_next = sppm_pkg::SPPM_DISP_NORMAL;
            else if (pkt_msg_i && pkt_self_i)
                disp_next = sppm_pkg::SPPM_DISP_NORMAL;
            else
                disp_next = sppm_pkg::SPPM_DISP_UR;
        end
    end

    // turn-off aggregation
    always_comb
    begin
        ag_next   = ag_reg;
        ack_next  = 1'b0;
        l23_next  = l23_reg;
        aban_next = 1'b0;
        fwd_next  = 2'b00;
        hold_next = hold_reg;
        send_next = 2'b00;
        for (int d = 0; d < 2; d++)
        begin
            if (hold_reg[d] && dn_l0_i[d])
            begin
                hold_next[d] = 1'b0;
                send_next[d] = 1'b1;
            end
        end
        // a new packet for a port is held even in the cycle the held one is sent
        if (up_pkt_i && !up_pkt_self_i)
            hold_next = hold_next | up_pkt_dn_i;
        case (ag_reg)
            sppm_pkg::SPPM_AG_IDLE:
                if (turnoff_i)
                begin
                    fwd_next = dn_active_i;
                    ag_next  = sppm_pkg::SPPM_AG_WAIT;
                end
            sppm_pkg::SPPM_AG_WAIT:
                if (up_pkt_i)
                begin
                    aban_next = 1'b1;
                    ag_next   = sppm_pkg::SPPM_AG_IDLE;
                end
                // acks of an earlier round clear the cycle after forwarding
                else if (fwd_reg == 2'b00
                         && (dn_acked | ~dn_active_i) == 2'b11)
                begin
                    ack_next = 1'b1;
                    l23_next = 1'b1;
                    ag_next  = sppm_pkg::SPPM_AG_DONE;
                end
            sppm_pkg::SPPM_AG_DONE:
                if (turnoff_i)
                begin
                    fwd_next = dn_active_i;
                    l23_next = 1'b0;
                    ag_next  = sppm_pkg::SPPM_AG_WAIT;
                end
                else if (pm_reg[0] != sppm_pkg::SPPM_D3_HOT && !d3cold_i)
                begin
                    l23_next = 1'b0;
                    ag_next  = sppm_pkg::SPPM_AG_IDLE;
                end
            default:
                ag_next = sppm_pkg::SPPM_AG_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ag_reg   <= sppm_pkg::SPPM_AG_IDLE;
            ack_reg  <= 1'b0;
            l23_reg  <= 1'b0;
            aban_reg <= 1'b0;
            fwd_reg  <= 2'b00;
            hold_reg <= 2'b00;
            send_reg <= 2'b00;
            disp_reg <= 2'b00;
            erpt_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            ag_reg   <= ag_next;
            ack_reg  <= ack_next;
            l23_reg  <= l23_next;
            aban_reg <= aban_next;
            fwd_reg  <= fwd_next;
            hold_reg <= hold_next;
            send_reg <= send_next;
            disp_reg <= disp_next;
            erpt_reg <= erpt_next;
        end
    end

    // wake allowed from D0 or D3hot of port or switch, never in D3cold or once the turn-off handshake is done
    assign d3_seen = {2{!d3cold_i && ag_reg != sppm_pkg::SPPM_AG_DONE}};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_dn
            sppm_down_timer u_tmr
            (
                .clock_i    (clock_i),
                .rst_n_i    (rst_n_i),
                .ce_i       (ce_i),
                .wake_ok_i  (d3_seen[g]),
                .wake_ev_i  (hp_ev_i[g]),
                .wake_clr_i (wake_clr_i[g]),
                .wake_to_i  (wake_to_i[16*g +: 16]),
                .to_send_i  (fwd_reg[g]),
                .to_ack_i   (dn_ack_i[g]),
                .ack_to_i   (ack_to_i[16*g +: 16]),
                .wake_msg_o (wake_msg_o[g]),
                .wake_sts_o (wake_sts_o[g]),
                .acked_o    (dn_acked[g]),
                .ack_tout_o (dn_ack_tout_o[g])
            );
        end
    endgenerate

    assign dn_turnoff_o   = fwd_reg;
    assign up_ack_o       = ack_reg;
    assign up_l23_o       = l23_reg;
    assign sw_low_power_o = l23_reg && pm_state_o[0];
    assign dn_l23_o       = dn_acked;
    assign dn_wake_link_o = hold_reg & ~dn_l0_i;
    assign dn_send_o      = send_reg;
    assign up_drop_o      = (ag_reg == sppm_pkg::SPPM_AG_DONE);
    assign agg_abandon_o  = aban_reg;
    assign pkt_disp_o     = disp_reg;
    assign pkt_err_rpt_o  = erpt_reg;

    a_d3_filter_ur: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && pkt_vld_i && pkt_req_i && pkt_sec_i && pm_state_o[pkt_port_i]
        |=> pkt_disp_o == sppm_pkg::SPPM_DISP_UR) else $error("ur");
    a_ack_after_all: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        up_ack_o |-> $past(ag_reg) == sppm_pkg::SPPM_AG_WAIT && up_l23_o)
        else $error("ack");
    a_abandon_pkt: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        agg_abandon_o |-> $past(up_pkt_i) && !up_ack_o)
        else $error("abandon");
    a_fwd_turnoff: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && turnoff_i && ag_reg == sppm_pkg::SPPM_AG_IDLE
        |=> dn_turnoff_o == $past(dn_active_i)) else $error("fwd");
    a_l1_in_d3: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        l1_req_o == pm_state_o && ps_rdata_o[1:0] == {2{pm_state_o[0]}})
        else $error("l1");
    a_d3_exit_uninit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ce_i && pm_state_o[0] && ps_wr_i[0] && ps_wdata_i[1:0] == 2'h0
        |=> pm_reg[0] == sppm_pkg::SPPM_D0_UNINIT) else $error("d0");
    a_no_wake_cold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(d3cold_i) && $past(ce_i) |-> wake_msg_o == 2'b00)
        else $error("cold");
    a_other_err_drop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pm_state_o[1] |-> !oth_err_rpt_o[1]) else $error("err");
    c_abandon: cover property (@(posedge clock_i) agg_abandon_o);
    c_ack: cover property (@(posedge clock_i) up_ack_o);
    c_tout: cover property (@(posedge clock_i) dn_ack_tout_o != 2'b00);
    c_wake: cover property (@(posedge clock_i) wake_msg_o[0]);
endmodule

// file: dv/sppm_link_partner.sv
// downstream link partners that acknowledge a forwarded turn-off
// assumes the core clock; mute_i keeps a port silent
`timescale 1ns/1ps
module sppm_link_partner
#(parameter int DLY = 3)
(
    input  wire logic       clock_i,   // core clock
    input  wire logic       rst_n_i,   // sync reset
    input  wire logic [1:0] turnoff_i, // forwarded turn-off
    input  wire logic [1:0] mute_i,    // never acknowledge
    output logic      [1:0] ack_o      // acknowledge pulse
);
    int cnt [2];
    always @(posedge clock_i)
    begin
        for (int d = 0; d < 2; d++)
        begin
            ack_o[d] <= (cnt[d] == 1);
            if (!rst_n_i)
                cnt[d] <= 0;
            else if (turnoff_i[d] && !mute_i[d])
                cnt[d] <= DLY;
            else if (cnt[d] > 0)
                cnt[d] <= cnt[d] - 1;
        end
    end
endmodule

// file: dv/switch_port_power_management_test.sv
// self-checking bench for the switch port power block
// assumes sppm_top and the link partner model; 50 MHz clock
`timescale 1ns/1ps
module switch_port_power_management_test;
    logic clock_i = 0, rst_n_i = 0, ce_i = 1, d3cold_i = 0, turnoff_i = 0;
    logic pkt_vld_i = 0, pkt_sec_i = 0, pkt_req_i = 0, pkt_cfg0_i = 0;
    logic pkt_msg_i = 0, pkt_self_i = 0, pkt_err_i = 0;
    logic up_pkt_i = 0, up_pkt_self_i = 0;
    logic [2:0] cfg_done_i = 0, ps_wr_i = 0, oth_err_i = 0, d3 = 0;
    logic [5:0] ps_wdata_i = 0, ps_rdata_o, rv;
    logic [1:0] pkt_port_i = 0, hp_ev_i = 0, wake_clr_i = 0, dn_l0_i = 3;
    logic [1:0] dn_active_i = 3, up_pkt_dn_i = 0, mute = 0, dn_ack_i;
    logic [31:0] wake_to_i = {2{16'h0008}}, ack_to_i = {2{16'h000C}};
    logic [2:0] context_kept_o, pm_state_o, l1_req_o, oth_err_rpt_o;
    logic sw_low_power_o, pkt_err_rpt_o, up_ack_o, up_l23_o, up_drop_o;
    logic agg_abandon_o;
    logic [1:0] pkt_disp_o, wake_msg_o, wake_sts_o, dn_turnoff_o, dn_l23_o;
    logic [1:0] dn_ack_tout_o, dn_wake_link_o, dn_send_o;
    int num_errors = 0, n_compared = 0, cyc = 0, n, pt;
    sppm_top dut (.clock_i, .rst_n_i, .ce_i, .cfg_done_i, .ps_wr_i,
        .ps_wdata_i, .ps_rdata_o, .context_kept_o, .pm_state_o, .l1_req_o,
        .sw_low_power_o, .pkt_vld_i, .pkt_port_i, .pkt_sec_i, .pkt_req_i,
        .pkt_cfg0_i, .pkt_msg_i, .pkt_self_i, .pkt_err_i, .pkt_disp_o,
        .pkt_err_rpt_o, .oth_err_i, .oth_err_rpt_o, .hp_ev_i, .wake_clr_i,
        .wake_to_i, .ack_to_i, .d3cold_i, .wake_msg_o, .wake_sts_o,
        .turnoff_i, .dn_active_i, .dn_l0_i, .dn_ack_i, .up_pkt_i,
        .up_pkt_self_i, .up_pkt_dn_i, .dn_turnoff_o, .up_ack_o, .up_l23_o,
        .dn_l23_o, .dn_ack_tout_o, .dn_wake_link_o, .dn_send_o, .up_drop_o,
        .agg_abandon_o);
    sppm_link_partner lp (.clock_i, .rst_n_i, .turnoff_i(dn_turnoff_o),
        .mute_i(mute), .ack_o(dn_ack_i));
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    task ck(input logic [7:0] g, input logic [7:0] x);
        n_compared++;
        if (g !== x)
        begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task tk(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    task smp();
        @(negedge clock_i);
    endtask
    task rst();
        tk(1);
        rst_n_i <= 0;
        tk(20);
        rst_n_i <= 1;
    endtask
    task set_ps(input int p, input logic [1:0] c);
        tk(1);
        ps_wr_i <= 3'h1 << p;
        ps_wdata_i <= {3{c}};
        tk(1);
        ps_wr_i <= 0;
        d3[p] = (c == 2'h3);
        smp();
    endtask
    task handshake();
        tk(1);
        turnoff_i <= 1;
        tk(1);
        turnoff_i <= 0;
        smp();
        ck(dn_turnoff_o, dn_active_i);
        n = 0;
        repeat (40)
        begin
            smp();
            n += up_ack_o;
        end
    endtask
    // model of the D3hot packet filter
    function logic [1:0] fexp(input logic d, s, r, c, m, f);
        if (!d)
            return 2'h0;
        if (r)
            return (!s && (c || (m && f))) ? 2'h0 : 2'h1;
        return f ? 2'h2 : 2'h0;
    endfunction
    initial
    begin
        void'($urandom(14));
        tk(20);
        rst_n_i <= 1;
        smp();
        ck(ps_rdata_o, 0);
        ck(context_kept_o, 3'h7);
        $display("reset test done");
        tk(1);
        cfg_done_i <= 3'h7;
        for (int p = 0; p < 3; p++)
        begin
            set_ps(p, 2'h3);
            ck(ps_rdata_o[2*p+:2], 2'h3);
            ck(l1_req_o, d3);
        end
        set_ps(2, 2'h0);
        ck(ps_rdata_o, 6'h0F);
        ck(pm_state_o, 3'h3);
        tk(1);
        oth_err_i <= 3'h7;
        smp();
        ck(oth_err_rpt_o, 3'h4);
        tk(1);
        ce_i <= 0;
        ps_wr_i <= 2;
        ps_wdata_i <= 0;
        tk(1);
        ps_wr_i <= 0;
        ce_i <= 1;
        smp();
        ck(pm_state_o, 3'h3);
        $display("state test done");
        repeat (40)
        begin
            rv = $urandom;
            pt = $urandom_range(2);
            if (!rv[1] || rv[2])
                rv[3] = 0;
            tk(1);
            pkt_vld_i <= 1;
            pkt_port_i <= pt[1:0];
            {pkt_err_i, pkt_self_i, pkt_msg_i, pkt_cfg0_i, pkt_req_i,
                pkt_sec_i} <= rv;
            tk(1);
            pkt_vld_i <= 0;
            smp();
            ck(pkt_disp_o, fexp(d3[pt], rv[0], rv[1], rv[2], rv[3], rv[4]));
            ck(pkt_err_rpt_o, rv[5]);
        end
        $display("filter test done");
        tk(1);
        d3cold_i <= 1;
        hp_ev_i <= 1;
        tk(1);
        hp_ev_i <= 0;
        n = 0;
        repeat (12)
        begin
            smp();
            n += wake_msg_o[0];
        end
        ck(n, 0);
        tk(1);
        d3cold_i <= 0;
        hp_ev_i <= 2;
        tk(1);
        hp_ev_i <= 0;
        smp();
        ck(wake_msg_o, 2);
        n = 0;
        do
        begin
            smp();
            n++;
        end while (wake_msg_o[1] !== 1'b1 && n < 50);
        ck(n, 8);
        ck(wake_sts_o, 2);
        tk(1);
        wake_clr_i <= 2;
        tk(1);
        wake_clr_i <= 0;
        n = 0;
        repeat (12)
        begin
            smp();
            n += wake_msg_o[1];
        end
        ck(n, 0);
        ck(wake_sts_o, 0);
        $display("wake test done");
        handshake();
        ck(n, 1);
        ck(up_l23_o, 1);
        ck(sw_low_power_o, 1);
        ck(up_drop_o, 1);
        set_ps(0, 2'h0);
        tk(1);
        hp_ev_i <= 1;
        tk(1);
        hp_ev_i <= 0;
        smp();
        ck(wake_msg_o[0], 1);
        rst();
        mute <= 2;
        handshake();
        ck(n, 1);
        ck(dn_ack_tout_o, 2);
        $display("handshake test done");
        rst();
        mute <= 3;
        dn_l0_i <= 1;
        tk(1);
        turnoff_i <= 1;
        tk(1);
        turnoff_i <= 0;
        tk(2);
        up_pkt_i <= 1;
        up_pkt_dn_i <= 2;
        tk(1);
        up_pkt_i <= 0;
        smp();
        ck(agg_abandon_o, 1);
        ck(dn_wake_link_o, 2);
        tk(1);
        dn_l0_i <= 3;
        n = 0;
        repeat (40)
        begin
            smp();
            n += dn_send_o[1] + 2 * up_ack_o;
        end
        ck(n, 1);
        ck(dn_l23_o, 3);
        $display("abandon test done");
        give_verdict();
    end
endmodule
